// File: inc/sram_cycle_pkg.sv
// constants and types shared by the burst sram cycle control
// assumes a single core clock; memory array lives in the sram_array module
package sram_cycle_pkg;
    localparam int ADDR_W = 18;
    localparam int LANE_W = 9;
    localparam int LANES  = 2;
    localparam int DATA_W = LANE_W * LANES;
    localparam logic [1:0] CNT_RESET = 2'h0;

    typedef enum logic [1:0] {
        OP_IDLE  = 2'b00,
        OP_READ  = 2'b01,
        OP_WRITE = 2'b11
    } op_t;
endpackage

// File: inc/sram_write_if.sv
// write request carrier between cycle control and the array module
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface sram_write_if;
    import sram_cycle_pkg::*;
    logic                  wr_en;
    logic [ADDR_W-1:0]     wr_addr;
    logic [LANES-1:0]      wr_lane;
    logic [DATA_W-1:0]     wr_data;
    logic [ADDR_W-1:0]     rd_addr;
    logic [DATA_W-1:0]     rd_data;
    modport ctrl (output wr_en, wr_addr, wr_lane, wr_data, rd_addr,
                  input rd_data);
    modport mem  (input wr_en, wr_addr, wr_lane, wr_data, rd_addr,
                  output rd_data);
endinterface

// File: design/sram_array.sv
// storage array with per-lane write masking and flow-through read
// assumes writes are already qualified by the cycle control
`timescale 1ns/1ps
module sram_array
    import sram_cycle_pkg::*;
#(
    parameter int DEPTH_W = ADDR_W
) (
    // clock
    input  wire logic core_clk_in,
    input  wire logic clk_en_in,
    // access
    sram_write_if.mem port
);
    logic [DATA_W-1:0] mem_array [2**DEPTH_W];

    // no reset: array contents are undefined after power-up anyway
    always_ff @(posedge core_clk_in) begin
        if (clk_en_in && port.wr_en) begin
            for (int i = 0; i < LANES; i++) begin
                if (port.wr_lane[i]) begin
                    mem_array[port.wr_addr[DEPTH_W-1:0]][i*LANE_W +: LANE_W]
                        <= port.wr_data[i*LANE_W +: LANE_W];
                end
            end
        end
    end

    assign port.rd_data = mem_array[port.rd_addr[DEPTH_W-1:0]];
endmodule

// File: design/sync_burst_sram_cycle_control.sv
// cycle decode, burst counter and i/o control of a flow-through sram
// assumes all pins are synchronous to core_clk_in except output enable and the asynchronous rst_in
`timescale 1ns/1ps
module sync_burst_sram_cycle_control
    import sram_cycle_pkg::*;
(
    // clock and reset
    input  wire logic                  core_clk_in,
    input  wire logic                  rst_in,
    input  wire logic                  clk_en_in,
    // control pins
    input  wire logic                  chip_select_a_n_in,
    input  wire logic                  chip_select_b_in,
    input  wire logic                  chip_select_c_n_in,
    input  wire logic                  clock_qualify_n_in,
    input  wire logic                  burst_step_or_load_in,
    input  wire logic                  write_n_in,
    input  wire logic [LANES-1:0]      byte_lane_mask_n_in,
    input  wire logic                  burst_order_in,
    input  wire logic                  output_enable_n_in,
    // address and data
    input  wire logic [ADDR_W-1:0]     addr_in,
    input  wire logic [15:0]           data_in,
    input  wire logic [LANES-1:0]      parity_lines_in,
    output logic      [15:0]           data_out,
    output logic      [LANES-1:0]      parity_lines_out,
    output logic                       data_oe_out
);
    import sram_cycle_pkg::*;

    typedef struct packed {
        op_t               op;
        logic [ADDR_W-1:0] base;
        logic [1:0]        cnt;
        logic              wr_pend;
        logic [ADDR_W-1:0] wr_addr;
        logic [LANES-1:0]  wr_lane;
        logic [DATA_W-1:0] rd_data;
        logic              rd_valid;
    } state_t;

    state_t state_reg;
    state_t state_next;

    sram_write_if wif ();

    sram_array u_array (
        .core_clk_in (core_clk_in),
        .clk_en_in   (clk_en_in),
        .port        (wif.mem)
    );

    function automatic logic [1:0] burst_addr(input logic [1:0] start,
                                              input logic [1:0] cnt,
                                              input logic       inter);
        burst_addr = inter ? (start ^ cnt) : 2'(start + cnt);
    endfunction

    logic                  selected;
    logic                  qualified;
    logic [1:0]            next_cnt;
    logic [ADDR_W-1:0]     cur_addr;

    assign selected  = !chip_select_a_n_in && chip_select_b_in
                       && !chip_select_c_n_in;
    assign qualified = clk_en_in && !clock_qualify_n_in;
    assign next_cnt  = 2'(state_reg.cnt + 2'h1);
    assign cur_addr  = {state_reg.base[ADDR_W-1:2],
                        burst_addr(state_reg.base[1:0], next_cnt,
                                   burst_order_in)};

    // write data lands one recognized clock after the access cycle
    assign wif.wr_en   = qualified && state_reg.wr_pend;
    assign wif.wr_addr = state_reg.wr_addr;
    assign wif.wr_lane = state_reg.wr_lane;
    assign wif.wr_data = {parity_lines_in[1], data_in[15:8],
                          parity_lines_in[0], data_in[7:0]};
    assign wif.rd_addr = (burst_step_or_load_in) ? cur_addr : addr_in;

    always_comb begin
        state_next = state_reg;
        if (qualified) begin
            state_next.wr_pend  = 1'b0;
            state_next.rd_valid = 1'b0;
            if (!burst_step_or_load_in) begin
                if (!selected) begin
                    state_next.op = OP_IDLE;
                end else begin
                    state_next.base = addr_in;
                    state_next.cnt  = CNT_RESET;
                    state_next.op   = write_n_in ? OP_READ : OP_WRITE;
                end
            end else if (state_reg.op != OP_IDLE) begin
                state_next.cnt = next_cnt;
            end
            // access address of the cycle just decoded
            if (state_next.op == OP_WRITE) begin
                state_next.wr_pend = 1'b1;
                state_next.wr_addr = burst_step_or_load_in ? cur_addr
                                                            : addr_in;
                state_next.wr_lane = ~byte_lane_mask_n_in;
            end else if (state_next.op == OP_READ) begin
                // byte lane masks unused on reads
                state_next.rd_valid = 1'b1;
                state_next.rd_data  = wif.rd_data;
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign data_out         = {state_reg.rd_data[16:9],
                               state_reg.rd_data[7:0]};
    assign parity_lines_out = {state_reg.rd_data[17],
                               state_reg.rd_data[8]};
    // output enable is asynchronous; writes never drive the bus
    assign data_oe_out = state_reg.rd_valid && !state_reg.wr_pend
                         && !output_enable_n_in;
endmodule

// File: sim/sync_burst_sram_cycle_control_monitor.sv
// port checker for the burst sram cycle control
// assumes it is bound into the top module
`timescale 1ns/1ps
module sync_burst_sram_cycle_control_monitor (
    // clock and reset
    input wire logic        core_clk_in,
    input wire logic        rst_in,
    input wire logic        clk_en_in,
    // control pins
    input wire logic        chip_select_a_n_in,
    input wire logic        chip_select_b_in,
    input wire logic        chip_select_c_n_in,
    input wire logic        clock_qualify_n_in,
    input wire logic        burst_step_or_load_in,
    input wire logic        write_n_in,
    input wire logic        output_enable_n_in,
    // outputs
    input wire logic [15:0] data_out,
    input wire logic        data_oe_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    wire tk = clk_en_in && !clock_qualify_n_in;
    wire ld = tk && !burst_step_or_load_in;
    wire sel = !chip_select_a_n_in && chip_select_b_in && !chip_select_c_n_in;
    sequence s_rd; ld && sel && write_n_in; endsequence
    sequence s_wr; ld && sel && !write_n_in; endsequence
    sequence s_step; tk && burst_step_or_load_in; endsequence
    oe_gate_a: assert property (
        output_enable_n_in |-> !data_oe_out) else $error("drive with oe");
    write_float_a: assert property (
        s_wr |=> !data_oe_out) else $error("drive in write");
    desel_float_a: assert property (
        ld && !sel |=> !data_oe_out) else $error("drive deselected");
    read_drive_a: assert property (
        s_rd ##1 !output_enable_n_in |-> data_oe_out) else $error("no read");
    burst_read_a: assert property (
        s_rd ##1 s_step ##1 !output_enable_n_in |-> data_oe_out)
        else $error("no burst read");
    burst_write_a: assert property (
        s_wr ##1 s_step |=> !data_oe_out) else $error("burst type lost");
    suspend_hold_a: assert property (
        !tk |=> $stable(data_out)) else $error("moved in suspend");
    reset_float_a: assert property (
        $past(rst_in) |-> !data_oe_out) else $error("drive at power-up");
endmodule
bind sync_burst_sram_cycle_control sync_burst_sram_cycle_control_monitor
    u_mon (.*);

// File: sim/sram_host_model.sv
// far-side memory controller model, one bus cycle per call
// assumes the bench calls cyc back to back; pins change at falling edge
`timescale 1ns/1ps
module sram_host_model (
    // clock
    input  wire logic   clk_in,
    // pins: ctl is oe_n, three selects, qualify_n, step_or_load, write_n
    output logic [6:0]  ctl_out,
    output logic [1:0]  mask_n_out,
    output logic [17:0] addr_out,
    output logic [17:0] wdata_out
);
    initial begin
        ctl_out = 7'h41;
        mask_n_out = 2'h3;
        addr_out = 18'h0;
        wdata_out = 18'h0;
    end
    // oe_n is driven as the caller passes it; t_mask_freeze holds it low on write cycles
    task automatic cyc(input logic [6:0] c, input logic [1:0] m,
                       input logic [17:0] a, input logic [17:0] d);
        @(negedge clk_in);
        ctl_out = c;
        mask_n_out = m;
        addr_out = a;
        wdata_out = d;
        @(posedge clk_in);
        #1;
    endtask
endmodule

// File: sim/tb_sync_burst_sram_cycle_control.sv
// self-checking bench for the burst sram cycle control
// assumes the host model drives every control pin except burst_order_in
`timescale 1ns/1ps
module tb_sync_burst_sram_cycle_control;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        order = 1'b0;
    logic        ce = 1'b1;
    logic [6:0]  c;
    logic [1:0]  m;
    logic [17:0] a;
    logic [17:0] w;
    logic [15:0] q;
    logic [1:0]  qp;
    logic        oe;
    int          n_errors = 0;
    int          checks_done = 0;
    logic [6:0]  rc [6] = '{7'h11, 7'h2A, 7'h17, 7'h2A, 7'h2A, 7'h2A};
    logic [17:0] re [6] = '{18'h2C3C1, 18'h2C3C0, 18'h2C3C0, 18'h2C3C3,
                            18'h3C3FF, 18'h2C3C1};
    always #25 clk = ~clk;
    sram_host_model host (.clk_in(clk), .ctl_out(c), .mask_n_out(m),
                          .addr_out(a), .wdata_out(w));
    sync_burst_sram_cycle_control DUT (
        .core_clk_in(clk), .rst_in(rst), .clk_en_in(ce),
        .chip_select_a_n_in(c[5]), .chip_select_b_in(c[4]),
        .chip_select_c_n_in(c[3]), .clock_qualify_n_in(c[2]),
        .burst_step_or_load_in(c[1]), .write_n_in(c[0]),
        .byte_lane_mask_n_in(m), .burst_order_in(order),
        .output_enable_n_in(c[6]), .addr_in(a), .data_in(w[15:0]),
        .parity_lines_in(w[17:16]), .data_out(q),
        .parity_lines_out(qp), .data_oe_out(oe));
    task automatic cmp(input string s, input logic [17:0] e, g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic conclude;
        if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic t_write; // linear burst of four, then one lane
        host.cyc(7'h50, 2'h0, 18'h10, 18'h0);
        for (int i = 0; i < 4; i++)
            host.cyc(i < 3 ? 7'h6B : 7'h41, 2'h0, 18'h0,
                     18'(18'h2C3C0 + i));
        host.cyc(7'h50, 2'h2, 18'h12, 18'h0);
        host.cyc(7'h41, 2'h0, 18'h0, 18'h3FFFF);
    endtask
    task automatic t_inter_read; // masks left active to show reads ignore them
        @(negedge clk) order = 1'b1;
        for (int i = 0; i < 6; i++) begin
            host.cyc(rc[i], 2'h0, 18'h11, 18'h0);
            cmp("read data", re[i], {qp, q});
        end
    endtask
    task automatic t_float_linear;
        @(negedge clk) order = 1'b0;
        host.cyc(7'h6B, 2'h3, 18'h0, 18'h0);
        cmp("drive", 18'h0, {17'h0, oe});
        host.cyc(7'h01, 2'h3, 18'h0, 18'h0);
        cmp("drive", 18'h0, {17'h0, oe});
        host.cyc(7'h11, 2'h3, 18'h13, 18'h0);
        host.cyc(7'h2A, 2'h3, 18'h0, 18'h0);
        cmp("read data", 18'h2C3C0, {qp, q});
    endtask
    task automatic t_mask_freeze; // oe low on writes, per-beat masks, freeze
        host.cyc(7'h10, 2'h3, 18'h10, 18'h0);
        cmp("drive", 18'h0, {17'h0, oe});
        host.cyc(7'h2B, 2'h1, 18'h0, 18'h1ABCD);
        cmp("drive", 18'h0, {17'h0, oe});
        host.cyc(7'h41, 2'h3, 18'h0, 18'h25A5A);
        host.cyc(7'h11, 2'h0, 18'h10, 18'h0);
        cmp("read data", 18'h2C3C0, {qp, q});
        @(negedge clk) ce = 1'b0;
        host.cyc(7'h2A, 2'h0, 18'h0, 18'h0);
        cmp("read data", 18'h2C3C0, {qp, q});
        @(negedge clk) ce = 1'b1;
        @(posedge clk) #1;
        cmp("read data", 18'h25AC1, {qp, q});
    endtask
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        cmp("drive", 18'h0, {17'h0, oe});
        t_write();
        t_inter_read();
        t_float_linear();
        t_mask_freeze();
        conclude();
    end
    initial begin
        repeat (500) @(posedge clk);
        n_errors++;
        conclude();
    end
endmodule
